// ---- logic/timer_pkg.sv ----
// shared constants and types for the eight-bit timer/counter core
package timer_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL_A  = 8'h00; // control_register_a
  localparam logic [7:0] OFF_CTRL_B  = 8'h04; // control_register_b
  localparam logic [7:0] OFF_COUNT   = 8'h08; // count_value
  localparam logic [7:0] OFF_CMP_A   = 8'h0c; // compare_value_a
  localparam logic [7:0] OFF_CMP_B   = 8'h10; // compare_value_b
  localparam logic [7:0] OFF_FLAGS   = 8'h14; // timer_flag_register
  localparam logic [7:0] OFF_MASK    = 8'h18; // timer_mask_register

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int WGM_LO_LSB = 0;  // waveform mode bits 1:0 in control a
  localparam int CS_LSB     = 0;  // clock_select_field in control b
  localparam int WGM_HI_BIT = 3;  // waveform mode bit 2 in control b
  localparam int OVF_BIT    = 0;  // overflow_flag position
  localparam int CMPA_BIT   = 1;  // compare_flag_a position
  localparam int CMPB_BIT   = 2;  // compare_flag_b position

  // ****************************************************************
  // reset values and count extremes
  // ****************************************************************
  localparam logic [7:0] RST_BYTE   = 8'h00; // counter and compares
  localparam logic [2:0] RST_FIELD  = 3'h0;  // mode and clock select
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // ****************************************************************
  // waveform mode codes
  // ****************************************************************
  localparam logic [2:0] WGM_NORMAL  = 3'h0;
  localparam logic [2:0] WGM_PC_FF   = 3'h1; // phase correct, top max
  localparam logic [2:0] WGM_CTC     = 3'h2; // clear on compare a
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PC_A    = 3'h5; // phase correct, top a
  localparam logic [2:0] WGM_FAST_A  = 3'h7;

  // ****************************************************************
  // clock select codes and prescale taps (count masks)
  // ****************************************************************
  localparam logic [2:0] CS_NONE   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [9:0] TAP_8    = 10'h007;
  localparam logic [9:0] TAP_64   = 10'h03f;
  localparam logic [9:0] TAP_256  = 10'h0ff;
  localparam logic [9:0] TAP_1K   = 10'h3ff;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic cmpb;  // compare_flag_b
    logic cmpa;  // compare_flag_a
    logic ovf;   // overflow_flag
  } flags_t;

  typedef struct packed {
    logic [2:0] wgm;  // waveform_mode_field
    logic [2:0] cs;   // clock_select_field
  } ctrl_t;

endpackage : timer_pkg

// ---- logic/tick_select.sv ----
// timer tick source: prescaler taps or synchronised external count pin
`timescale 1ns/1ps
`default_nettype none
module tick_select (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       external_count_pin,
  output logic            timer_tick
);

  // ****************************************************************
  // pin synchroniser and edge history
  // ****************************************************************
  logic       pin_meta_q;  // first stage, read only by second
  logic       pin_sync_q;  // second stage
  logic       pin_last_q;  // delayed copy for edge detect
  logic [9:0] pre_q;       // free-running prescaler

  // two flops before anything looks at the pin
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_last_q <= 1'b0;
    end else begin
      pin_meta_q <= external_count_pin;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  // prescaler never resets mid-run, so first divided tick may be early
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // ****************************************************************
  // source and edge choice
  // ****************************************************************
  always_comb begin
    case (clock_select_field)
      timer_pkg::CS_NONE:     timer_tick = 1'b0;
      timer_pkg::CS_DIV1:     timer_tick = 1'b1;
      timer_pkg::CS_DIV8:     timer_tick = (pre_q & timer_pkg::TAP_8) == timer_pkg::TAP_8;
      timer_pkg::CS_DIV64:    timer_tick = (pre_q & timer_pkg::TAP_64) == timer_pkg::TAP_64;
      timer_pkg::CS_DIV256:   timer_tick = (pre_q & timer_pkg::TAP_256) == timer_pkg::TAP_256;
      timer_pkg::CS_DIV1K:    timer_tick = pre_q == timer_pkg::TAP_1K;
      timer_pkg::CS_EXT_FALL: timer_tick = pin_last_q & ~pin_sync_q;
      default:                timer_tick = ~pin_last_q & pin_sync_q;
    endcase
  end

endmodule : tick_select
`default_nettype wire

// ---- logic/timer_counter.sv ----
// eight-bit up/down timer/counter with two compare units, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module timer_counter (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        EXT_COUNT_PIN,
  input  wire logic [2:0]  IRQ_ACK,
  output logic      [2:0]  IRQ,
  output logic             COUNT_BOTTOM,
  output logic             COUNT_MAX,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic      [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == timer_pkg::OFF_CTRL_A || a == timer_pkg::OFF_CTRL_B ||
             a == timer_pkg::OFF_COUNT  || a == timer_pkg::OFF_CMP_A  ||
             a == timer_pkg::OFF_CMP_B  || a == timer_pkg::OFF_FLAGS  ||
             a == timer_pkg::OFF_MASK;
  endfunction : mapped

  // pwm modes: bit 0 set means fast or phase correct
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = m[0];
  endfunction : is_pwm

  function automatic logic is_phase(input logic [2:0] m);
    is_phase = m[0] & ~m[1];
  endfunction : is_phase

  // ****************************************************************
  // state
  // ****************************************************************
  timer_pkg::ctrl_t  ctrl_q;             // mode and clock select
  timer_pkg::flags_t flags_q;            // timer_flag_register
  timer_pkg::flags_t mask_q;             // timer_mask_register
  timer_pkg::flags_t flag_set;           // hardware events this cycle
  timer_pkg::flags_t flag_clr;           // service or write-one clears
  logic [7:0]  cnt_q, cnt_d;             // count_value
  logic        dir_q, dir_d;             // high while counting down
  logic [7:0]  cmpa_buf_q, cmpb_buf_q;   // processor-visible compares
  logic [7:0]  cmpa_q, cmpb_q;           // compares in use
  logic        block_q;                  // match suppression pending
  logic        tick;                     // timer_tick
  logic [7:0]  top;                      // top of sequence
  logic        ovf_ev;                   // overflow event
  logic        upd_pt;                   // compare buffer update point
  logic        aw_full_q, w_full_q;      // captured write halves
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q;                 // low byte lane enabled
  logic        wr_go;                    // write performed this edge
  logic [7:0]  wb;                       // written byte

  tick_select u_tick (
    .CLOCK              (CLOCK),
    .RST                (RST),
    .clock_select_field (ctrl_q.cs),
    .external_count_pin (EXT_COUNT_PIN),
    .timer_tick         (tick)
  );

  // ****************************************************************
  // axi4-lite write side
  // ****************************************************************
  assign S_AXI_AWREADY = ~aw_full_q;
  assign S_AXI_WREADY  = ~w_full_q;
  assign wr_go = aw_full_q & w_full_q & ~S_AXI_BVALID;
  assign wb    = w_data_q;

  // address and data may arrive in either order; each is held until used
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (S_AXI_WVALID && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // response, slverr for holes in the map
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= mapped(aw_addr_q) ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // write strobes per register, low lane only since registers are bytes
  logic wr_ctrl_a, wr_ctrl_b, wr_cnt, wr_cmpa, wr_cmpb, wr_flags, wr_mask;
  assign wr_ctrl_a = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_CTRL_A);
  assign wr_ctrl_b = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_CTRL_B);
  assign wr_cnt    = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_COUNT);
  assign wr_cmpa   = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_CMP_A);
  assign wr_cmpb   = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_CMP_B);
  assign wr_flags  = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_FLAGS);
  assign wr_mask   = wr_go & w_lane_q & (aw_addr_q == timer_pkg::OFF_MASK);

  // ****************************************************************
  // axi4-lite read side
  // ****************************************************************
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // one read at a time; data captured when the address is taken
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'h0;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? 2'h0 : 2'h2;
      case (S_AXI_ARADDR)
        timer_pkg::OFF_CTRL_A: S_AXI_RDATA <= {30'h0, ctrl_q.wgm[1:0]};
        timer_pkg::OFF_CTRL_B: S_AXI_RDATA <= {28'h0, ctrl_q.wgm[2], ctrl_q.cs};
        timer_pkg::OFF_COUNT:  S_AXI_RDATA <= {24'h0, cnt_q};
        timer_pkg::OFF_CMP_A:  S_AXI_RDATA <= {24'h0, cmpa_buf_q};
        timer_pkg::OFF_CMP_B:  S_AXI_RDATA <= {24'h0, cmpb_buf_q};
        timer_pkg::OFF_FLAGS:  S_AXI_RDATA <= {29'h0, flags_q};
        timer_pkg::OFF_MASK:   S_AXI_RDATA <= {29'h0, mask_q};
        default:               S_AXI_RDATA <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_q <= '{wgm: timer_pkg::RST_FIELD, cs: timer_pkg::RST_FIELD};
      mask_q <= '0;
    end else begin
      if (wr_ctrl_a) ctrl_q.wgm[1:0] <= wb[timer_pkg::WGM_LO_LSB +: 2];
      if (wr_ctrl_b) begin
        ctrl_q.wgm[2] <= wb[timer_pkg::WGM_HI_BIT];
        ctrl_q.cs     <= wb[timer_pkg::CS_LSB +: 3];
      end
      if (wr_mask) mask_q <= wb[2:0];
    end
  end

  // ****************************************************************
  // counter unit
  // ****************************************************************
  // top is compare a in ctc and in every mode with wgm2 set, else max
  assign top = (ctrl_q.wgm == timer_pkg::WGM_CTC || ctrl_q.wgm[2]) ?
               cmpa_q : timer_pkg::CNT_MAX;

  // fast pwm reloads compares at wrap, phase correct at top
  assign upd_pt = tick & (cnt_q == top) & (~is_phase(ctrl_q.wgm) | ~dir_q);

  always_comb begin
    cnt_d  = cnt_q;
    dir_d  = dir_q;
    ovf_ev = 1'b0;
    if (tick) begin
      if (is_phase(ctrl_q.wgm)) begin
        // up to top, back down to bottom; overflow at bottom
        if (!dir_q) begin
          if (cnt_q == top) begin
            dir_d = 1'b1;
            cnt_d = cnt_q - 8'h01;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end else if (cnt_q == timer_pkg::CNT_BOTTOM) begin
          dir_d  = 1'b0;
          cnt_d  = cnt_q + 8'h01;
          ovf_ev = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end else if (is_pwm(ctrl_q.wgm) || ctrl_q.wgm == timer_pkg::WGM_CTC) begin
        dir_d = 1'b0;
        if (cnt_q == top) begin
          cnt_d = timer_pkg::CNT_BOTTOM;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
        // fast pwm overflows at top, ctc at max
        ovf_ev = is_pwm(ctrl_q.wgm) ? (cnt_q == top)
                                    : (cnt_q == timer_pkg::CNT_MAX);
      end else begin
        dir_d  = 1'b0;
        cnt_d  = cnt_q + 8'h01;
        ovf_ev = cnt_q == timer_pkg::CNT_MAX;
      end
    end
    if (wr_cnt) cnt_d = wb;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_q <= timer_pkg::RST_BYTE;
      dir_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  assign COUNT_BOTTOM = cnt_q == timer_pkg::CNT_BOTTOM;
  assign COUNT_MAX    = cnt_q == timer_pkg::CNT_MAX;

  // ****************************************************************
  // compare units
  // ****************************************************************
  // buffered in pwm modes to keep pulses symmetrical; direct otherwise
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmpa_buf_q <= timer_pkg::RST_BYTE;
      cmpb_buf_q <= timer_pkg::RST_BYTE;
      cmpa_q     <= timer_pkg::RST_BYTE;
      cmpb_q     <= timer_pkg::RST_BYTE;
    end else begin
      if (wr_cmpa) cmpa_buf_q <= wb;
      if (wr_cmpb) cmpb_buf_q <= wb;
      if (!is_pwm(ctrl_q.wgm)) begin
        if (wr_cmpa) cmpa_q <= wb;
        if (wr_cmpb) cmpb_q <= wb;
      end else if (upd_pt) begin
        cmpa_q <= cmpa_buf_q;
        cmpb_q <= cmpb_buf_q;
      end
    end
  end

  // a count write arms the block; the next tick consumes it
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ****************************************************************
  // flags and requests
  // ****************************************************************
  // equality is sampled on the tick, flag appears the edge after
  assign flag_set.ovf  = ovf_ev;
  assign flag_set.cmpa = tick & ~block_q & ~wr_cnt & (cnt_q == cmpa_q);
  assign flag_set.cmpb = tick & ~block_q & ~wr_cnt & (cnt_q == cmpb_q);
  assign flag_clr = IRQ_ACK | (wr_flags ? wb[2:0] : 3'h0);

  // set wins over a clear in the same cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      flags_q <= '0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  assign IRQ = flags_q & mask_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  AST_STOPPED: assert property ((ctrl_q.cs == timer_pkg::CS_NONE && !wr_cnt) |=> $stable(cnt_q))
    else $error("counter moved with no clock selected");
  AST_WRITE_PRIO: assert property (wr_cnt |=> cnt_q == $past(wb))
    else $error("count write lost to counting");
  AST_CTC_CLEAR: assert property ((tick && !wr_cnt && ctrl_q.wgm == timer_pkg::WGM_CTC
    && cnt_q == cmpa_q) |=> cnt_q == 8'h00)
    else $error("ctc did not clear at compare a");
  AST_WRAP: assert property ((tick && !wr_cnt && ctrl_q.wgm == timer_pkg::WGM_NORMAL
    && cnt_q == 8'hff) |=> (cnt_q == 8'h00 && flags_q.ovf))
    else $error("normal mode wrap or overflow wrong");
  AST_MATCH_A: assert property ((tick && !block_q && !wr_cnt && cnt_q == cmpa_q)
    |=> flags_q.cmpa)
    else $error("compare a flag missing after match");
  // a tick in the write cycle or the first one after it never sets compare flag a
  AST_BLOCK: assert property ((tick && (block_q || wr_cnt)) |=> !$rose(flags_q.cmpa))
    else $error("match not blocked after count write");
  AST_ARM: assert property (wr_cnt |=> block_q)
    else $error("count write did not arm match block");
  AST_ACK: assert property ((IRQ_ACK[1] && !flag_set.cmpa) |=> !flags_q.cmpa)
    else $error("serviced compare flag not cleared");
  AST_DOWN: assert property ((tick && !wr_cnt && is_phase(ctrl_q.wgm) && dir_q
    && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("phase correct down count wrong");
  AST_MASK: assert property (!mask_q.ovf |-> !IRQ[0])
    else $error("masked overflow request raised");

  COV_CTC: cover property (ctrl_q.wgm == timer_pkg::WGM_CTC && flag_set.cmpa);
  COV_PHASE_TURN: cover property (tick && is_phase(ctrl_q.wgm) && dir_q && COUNT_BOTTOM);
  COV_SET_CLEAR: cover property (flag_set.cmpb && flag_clr.cmpb);

endmodule : timer_counter
`default_nettype wire

// ---- testbench/cpu_model.sv ----
// processor-side model: axi4-lite master and interrupt service pulses
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic        CLOCK,
  output logic             S_AXI_AWVALID,
  input  wire logic        S_AXI_AWREADY,
  output logic      [7:0]  S_AXI_AWADDR,
  output logic             S_AXI_WVALID,
  input  wire logic        S_AXI_WREADY,
  output logic      [31:0] S_AXI_WDATA,
  output logic      [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_BVALID,
  output logic             S_AXI_BREADY,
  input  wire logic [1:0]  S_AXI_BRESP,
  output logic             S_AXI_ARVALID,
  input  wire logic        S_AXI_ARREADY,
  output logic      [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_RVALID,
  output logic             S_AXI_RREADY,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic [1:0]  S_AXI_RRESP,
  output logic      [2:0]  IRQ_ACK
);
  // ****************
  // idle values
  // ****************
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB, IRQ_ACK} = 55'h0;
  end
  // ****************
  // bus cycles
  // ****************
  // write: both halves offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    @(posedge CLOCK);
    S_AXI_AWVALID <= 1'b1;
    S_AXI_AWADDR  <= a;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= 4'hf;
    while (aw_left || w_left) begin
      @(posedge CLOCK);
      // released payloads are scrambled so nothing leans on stale values
      if (aw_left && S_AXI_AWREADY === 1'b1) begin
        aw_left = 1'b0;
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR  <= ~a;
      end
      if (w_left && S_AXI_WREADY === 1'b1) begin
        w_left = 1'b0;
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA  <= ~d;
      end
    end
    S_AXI_BREADY <= 1'b1;
    do @(posedge CLOCK); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  // read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLOCK);
    S_AXI_ARVALID <= 1'b1;
    S_AXI_ARADDR  <= a;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLOCK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_ARADDR  <= ~a;
    do @(posedge CLOCK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  // one-cycle service pulse, as the interrupt handler entry gives
  task automatic ack(input logic [2:0] b);
    @(posedge CLOCK);
    IRQ_ACK <= b;
    @(posedge CLOCK);
    IRQ_ACK <= 3'h0;
  endtask : ack
endmodule : cpu_model
`default_nettype wire

// ---- testbench/tb_timer_counter.sv ----
// self-checking bench for the eight-bit timer/counter core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_timer_counter;
  logic        CLOCK, RST, EXT_COUNT_PIN, COUNT_BOTTOM, COUNT_MAX;
  logic [2:0]  IRQ_ACK, IRQ;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r, br;
  logic [31:0] d, d0;      // read data scratch
  int          failures;   // mismatches
  int          tests_run;  // comparisons
  typedef struct packed {
    logic [7:0] a; logic [31:0] w; logic [31:0] x; logic [1:0] s;
  } row_t;
  // upper data bits must not land; an unmapped word is refused
  row_t rows [5] = '{'{8'h0c, 32'h55, 32'h55, 2'h0}, '{8'h10, 32'hffffffaa, 32'haa, 2'h0},
    '{8'h18, 32'h07, 32'h07, 2'h0}, '{8'h08, 32'h3c, 32'h3c, 2'h0},
    '{8'h1c, 32'hff, 32'h00, 2'h2}};
  timer_counter i_timer_counter (.*);
  cpu_model     i_cpu_model (.*);
  initial CLOCK = 1'b0;
  always #5 CLOCK = ~CLOCK;
  // ****************
  // helpers
  // ****************
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    i_cpu_model.wr(a, v, br);
  endtask : w
  // pin held long enough to clear the synchroniser and edge detect
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge CLOCK) EXT_COUNT_PIN <= 1'b1;
      repeat (6) @(posedge CLOCK);
      EXT_COUNT_PIN <= 1'b0;
      repeat (6) @(posedge CLOCK);
    end
  endtask : pulse
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge CLOCK);
    failures++;
    give_verdict();
  end
  // ****************
  // tests
  // ****************
  initial begin
    RST = 1'b1;
    EXT_COUNT_PIN = 1'b0;
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].w);
      i_cpu_model.rd(rows[i].a, d, r);
      `CHK({br, r, d}, {rows[i].s, rows[i].s, rows[i].x})
    end
    $display("register rows done");
    // mid-run reset must clear everything again
    @(posedge CLOCK) RST <= 1'b1;
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    for (int a = 0; a <= 8'h18; a += 4) begin
      i_cpu_model.rd(8'(a), d, r);
      `CHK(d, 32'h0)
    end
    `CHK({COUNT_BOTTOM, COUNT_MAX, IRQ}, 5'h10)
    $display("reset done");
    // external rising edges: wrap to bottom sets overflow and match a
    w(timer_pkg::OFF_COUNT, 32'hfe);
    w(timer_pkg::OFF_CMP_A, 32'hff);
    w(timer_pkg::OFF_CTRL_B, 32'h07);
    pulse(1);
    `CHK(COUNT_MAX, 1'b1)
    pulse(1);
    `CHK(COUNT_BOTTOM, 1'b1)
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h3)
    w(timer_pkg::OFF_MASK, 32'h02);
    `CHK(IRQ, 3'b010)
    i_cpu_model.ack(3'b010);
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h1)
    w(timer_pkg::OFF_FLAGS, 32'h01);
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK({IRQ, d}, 35'h0)
    $display("overflow and compare a done");
    // falling edge select counts one on a full pin pulse
    w(timer_pkg::OFF_CTRL_B, 32'h06);
    pulse(1);
    i_cpu_model.rd(timer_pkg::OFF_COUNT, d, r);
    `CHK(d, 32'h1)
    // that tick left zero, which equals compare b since the reset
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h4)
    w(timer_pkg::OFF_FLAGS, 32'h04);
    // count write hides the next tick's match, the one after fires
    w(timer_pkg::OFF_CTRL_B, 32'h07);
    w(timer_pkg::OFF_CMP_B, 32'h05);
    w(timer_pkg::OFF_COUNT, 32'h05);
    pulse(1);
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h0)
    w(timer_pkg::OFF_COUNT, 32'h04);
    pulse(2);
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h4)
    $display("match blocking done");
    // write while counting every clock lands over the increments
    w(timer_pkg::OFF_CTRL_B, 32'h01);
    w(timer_pkg::OFF_COUNT, 32'h80);
    w(timer_pkg::OFF_CTRL_B, 32'h00);
    i_cpu_model.rd(timer_pkg::OFF_COUNT, d0, r);
    `CHK(d0[7:4], 4'h8)
    pulse(1);
    i_cpu_model.rd(timer_pkg::OFF_COUNT, d, r);
    `CHK(d, d0)
    $display("priority and stop done");
    // clear on compare a: 0,1,2 then back to zero, no overflow
    w(timer_pkg::OFF_CTRL_A, 32'h02);
    w(timer_pkg::OFF_CMP_A, 32'h02);
    w(timer_pkg::OFF_COUNT, 32'h00);
    w(timer_pkg::OFF_FLAGS, 32'h07);
    w(timer_pkg::OFF_CTRL_B, 32'h07);
    pulse(3);
    i_cpu_model.rd(timer_pkg::OFF_COUNT, d, r);
    `CHK(d, 32'h0)
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h2)
    $display("clear on compare done");
    // phase correct, top a: new compare a waits in its buffer until top
    // buffered: 0,1,2,1,0 after four ticks; unbuffered would give 2
    w(timer_pkg::OFF_CTRL_A, 32'h01);
    w(timer_pkg::OFF_CTRL_B, 32'h0f);
    w(timer_pkg::OFF_CMP_A, 32'h03);
    pulse(4);
    i_cpu_model.rd(timer_pkg::OFF_COUNT, d, r);
    `CHK(d, 32'h0)
    // turning up at bottom overflows; match a from the top stays set
    pulse(1);
    i_cpu_model.rd(timer_pkg::OFF_FLAGS, d, r);
    `CHK(d, 32'h3)
    $display("phase correct done");
    give_verdict();
  end
endmodule : tb_timer_counter
`undef CHK
`default_nettype wire
